// file: verilog/pmcsr_regs.vh
// Functional notes
// - Power reading field 31:24 reads zero; writes are ignored.
// - Reserved bits 23:16, 7:4 and 2 always read zero.
// - Power reading scale 14:13 and selector 12:9 read zero, ignore writes.
// - Wake-event enable bit 8 is read/write; one permits the wake signal.
// - Coming up from full power-off clears the wake-event enable bit.
// - Waking from cold low-power keeps the wake-event enable value.
// - No-soft-reset bit 3 always reads one.
// - Power-state field 1:0 reads current state; 00 D0 .. 11 D3hot.
// - D1 and D2 are unsupported; requests are dropped, capability says so.
`ifndef PMCSR_REGS_VH
`define PMCSR_REGS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define PMCSR_OFFSET        12'h0A4
`define PMCSR_RESET         32'h00000008
`define PMCSR_ENABLE_BIT    8
`define PMCSR_NOSOFT_BIT    3
`define PMCSR_STATE_MSB     1
`define PMCSR_STATE_LSB     0
`define PMCSR_ENABLE_RESET  1'h0
`define PMCSR_NOSOFT_VALUE  1'h1
`define PMCSR_CAP_VALUE     1'h0
`define PMCSR_ZERO_WORD     32'h00000000

// ----------------------------------------
// Byte lanes of a configuration write
// ----------------------------------------
`define PMCSR_LANE_STATE    2'h0
`define PMCSR_LANE_ENABLE   2'h1

// ----------------------------------------
// Power-state codes
// ----------------------------------------
`define PMCSR_ST_D0         2'h0
`define PMCSR_ST_D1         2'h1
`define PMCSR_ST_D2         2'h2
`define PMCSR_ST_D3HOT      2'h3

`endif

// file: verilog/pmcsr_pm_control_status_reg.v
`timescale 1ns/10ps
`include "pmcsr_regs.vh"

module pmcsr_pm_control_status_reg (
   // Clock and reset
   input  wire        clk_i,
   input  wire        rstn_i,
   // Wake-up kind: high when coming back from cold low-power
   input  wire        cold_wake_i,
   // Configuration access
   input  wire [11:0] cfg_addr_i,
   input  wire        cfg_wr_i,
   input  wire [3:0]  cfg_be_i,
   input  wire [31:0] cfg_wdata_i,
   output wire [31:0] cfg_rdata_o,
   // Block state
   output wire [1:0]  power_state_field_o,
   output wire        wake_event_enable_o,
   output wire        light_sleep_supported_o,
   output wire        deep_sleep_supported_o
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   // Stored fields of the register
   reg  [1:0]  power_state_ff;
   reg         wake_event_enable_ff;

   // Registered read data, zero when not addressed
   reg  [31:0] rdata_ff;

   // Capability flags for the intermediate states
   reg         cap_d1_ff;
   reg         cap_d2_ff;

   // Wake-kind synchroniser stages
   reg         cold_wake_meta_ff;
   reg         cold_wake_sync_ff;

   // Next values of the stored fields
   reg  [1:0]  nxt_power_state;
   reg         nxt_wake_event_enable;
   reg  [31:0] nxt_rdata;

   // Access decode
   wire        hit;
   wire        wr_hit;
   wire        state_lane;
   wire        enable_lane;
   wire [1:0]  req_state;
   wire        req_enable;
   wire        state_ok;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Only D0 and D3hot are implemented
   function supported_state;
      input [1:0] st;
      begin
         supported_state = (st == `PMCSR_ST_D0) ||
                           (st == `PMCSR_ST_D3HOT);
      end
   endfunction

   // Write strobe for one byte lane of this register
   function lane_write;
      input       wr;
      input [3:0] be;
      input [1:0] lane;
      begin
         lane_write = wr && be[lane];
      end
   endfunction

   // Assemble the readable word; all other bits are constant zero
   function [31:0] read_word;
      input [1:0] st;
      input       en;
      begin
         read_word = `PMCSR_ZERO_WORD;
         read_word[`PMCSR_NOSOFT_BIT] = `PMCSR_NOSOFT_VALUE;
         read_word[`PMCSR_ENABLE_BIT] = en;
         read_word[`PMCSR_STATE_MSB:`PMCSR_STATE_LSB] = st;
      end
   endfunction

   // ----------------------------------------
   // Wake-kind synchroniser
   // ----------------------------------------
   // Two stages before the wake kind reaches the reset logic.
   // No reset here: the value must pass while reset is held,
   // so the pin has to settle two edges before reset starts.
   always @(posedge clk_i) begin
      cold_wake_meta_ff <= cold_wake_i;
      cold_wake_sync_ff <= cold_wake_meta_ff;
   end

   // ----------------------------------------
   // Access decode
   // ----------------------------------------
   // Address match and per-lane write strobes
   assign hit         = (cfg_addr_i == `PMCSR_OFFSET);
   assign wr_hit      = hit && cfg_wr_i;
   assign state_lane  = lane_write(wr_hit, cfg_be_i, `PMCSR_LANE_STATE);
   assign enable_lane = lane_write(wr_hit, cfg_be_i, `PMCSR_LANE_ENABLE);

   // Requested field values from the write data
   assign req_state   = cfg_wdata_i[`PMCSR_STATE_MSB:`PMCSR_STATE_LSB];
   assign req_enable  = cfg_wdata_i[`PMCSR_ENABLE_BIT];

   // Requests for D1 or D2 are dropped
   assign state_ok    = supported_state(req_state);

   // ----------------------------------------
   // Next values
   // ----------------------------------------
   // Power state follows only supported requests
   always @* begin
      nxt_power_state = power_state_ff;
      if (state_lane && state_ok) begin
         nxt_power_state = req_state;
      end
   end

   // Wake-event enable is plain storage
   always @* begin
      nxt_wake_event_enable = wake_event_enable_ff;
      if (enable_lane) begin
         nxt_wake_event_enable = req_enable;
      end
   end

   // Read word shows the fields after any write in this cycle.
   // Other addresses return zero so a shared return path can OR.
   always @* begin
      nxt_rdata = `PMCSR_ZERO_WORD;
      if (hit) begin
         nxt_rdata = read_word(nxt_power_state, nxt_wake_event_enable);
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Power state returns to D0 on any reset
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         power_state_ff <= `PMCSR_ST_D0;
      end else begin
         power_state_ff <= nxt_power_state;
      end
   end

   // Power-off clears the enable, a cold wake keeps it.
   // The enable has no defined start value if the very first
   // reset is a cold wake, so first power-up must be power-off.
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         if (cold_wake_sync_ff) begin
            wake_event_enable_ff <= wake_event_enable_ff;
         end else begin
            wake_event_enable_ff <= `PMCSR_ENABLE_RESET;
         end
      end else begin
         wake_event_enable_ff <= nxt_wake_event_enable;
      end
   end

   // Read data register, cleared by reset
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         rdata_ff <= `PMCSR_ZERO_WORD;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // Capability bits report D1 and D2 unsupported
   always @(posedge clk_i) begin
      cap_d1_ff <= `PMCSR_CAP_VALUE;
      cap_d2_ff <= `PMCSR_CAP_VALUE;
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // All outputs come straight from flip-flops
   assign cfg_rdata_o             = rdata_ff;
   assign power_state_field_o     = power_state_ff;
   assign wake_event_enable_o     = wake_event_enable_ff;
   assign light_sleep_supported_o = cap_d1_ff;
   assign deep_sleep_supported_o  = cap_d2_ff;

endmodule

// file: bench/pmcsr_host.sv
`timescale 1ns/10ps
module pmcsr_host (
   input  wire        clk_i,
   output reg  [11:0] cfg_addr_o,
   output reg         cfg_wr_o,
   output reg  [3:0]  cfg_be_o,
   output reg  [31:0] cfg_wdata_o
);
   initial {cfg_addr_o, cfg_wr_o, cfg_be_o, cfg_wdata_o} = 49'h0;
   // One access a cycle, changed just after the edge
   task acc(input [11:0] a, input w, input [3:0] b, input [31:0] d);
      @(posedge clk_i) #1 {cfg_addr_o, cfg_wr_o, cfg_be_o, cfg_wdata_o} =
         {a, w, b, d};
   endtask
endmodule

// file: bench/pmcsr_sva.sv
`timescale 1ns/10ps
module pmcsr_sva (
   input wire        clk_i, rstn_i, cold_wake_i, cfg_wr_i,
   input wire [11:0] cfg_addr_i,
   input wire [3:0]  cfg_be_i,
   input wire [31:0] cfg_wdata_i, cfg_rdata_o,
   input wire [1:0]  power_state_field_o,
   input wire        wake_event_enable_o,
   input wire        light_sleep_supported_o, deep_sleep_supported_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // Accepted writes to the register
   wire wr = cfg_wr_i && cfg_addr_i == 12'h0A4;
   // Edges seen since start; wake-kind history is known from three on
   reg  [1:0] warm = 2'h0;
   always @(posedge clk_i) if (warm != 2'h3) warm <= warm + 2'h1;
   data_zero_a: assert property (cfg_rdata_o[31:24] == 8'h00)
      else $error("power data not zero");
   rsvd_zero_a: assert property ((cfg_rdata_o & 32'h00FF00F4) == 0)
      else $error("reserved bits set");
   status_zero_a: assert property (!cfg_rdata_o[15])
      else $error("wake status set");
   scale_zero_a: assert property
      (cfg_rdata_o[14:9] == 6'h00) else $error("scale or select set");
   enable_wr_a: assert property (wr && cfg_be_i[1] |=>
      wake_event_enable_o == $past(cfg_wdata_i[8])) else $error("enable");
   off_clear_a: assert property (disable iff (1'b0)
      warm == 2'h3 && !rstn_i && !$past(cold_wake_i, 2) |=>
      !wake_event_enable_o) else $error("clr");
   cold_keep_a: assert property (disable iff (1'b0)
      warm == 2'h3 && !rstn_i && $past(cold_wake_i, 2) |=>
      $stable(wake_event_enable_o)) else $error("k");
   state_wr_a: assert property
      (wr && cfg_be_i[0] && !(^cfg_wdata_i[1:0]) |=>
      power_state_field_o == $past(cfg_wdata_i[1:0])) else $error("st");
   unsup_drop_a: assert property
      (wr && cfg_be_i[0] && ^cfg_wdata_i[1:0] |=>
      $stable(power_state_field_o)) else $error("unsup");
   caps_zero_a: assert property
      (!light_sleep_supported_o && !deep_sleep_supported_o)
      else $error("capability set");
endmodule
bind pmcsr_pm_control_status_reg pmcsr_sva u_sva (.*);

// file: bench/pm_control_status_reg_tb_top.sv
`timescale 1ns/10ps
module pm_control_status_reg_tb_top;
   reg         clk_i = 0, rstn_i = 0, cold_wake_i = 0, en;
   wire [11:0] a;
   wire        w, ena, l1, l2;
   wire [3:0]  b;
   wire [31:0] d, q;
   wire [1:0]  s;
   reg  [1:0]  st;
   reg  [31:0] r;
   reg  [11:0] adr;
   integer     bad_count = 0, compares = 0, i;
   always #2.5 clk_i = ~clk_i;
   pmcsr_host HOST (.clk_i(clk_i), .cfg_addr_o(a), .cfg_wr_o(w),
      .cfg_be_o(b), .cfg_wdata_o(d));
   pmcsr_pm_control_status_reg DUT (.clk_i(clk_i), .rstn_i(rstn_i),
      .cold_wake_i(cold_wake_i), .cfg_addr_i(a), .cfg_wr_i(w), .cfg_be_i(b),
      .cfg_wdata_i(d), .cfg_rdata_o(q), .power_state_field_o(s),
      .wake_event_enable_o(ena), .light_sleep_supported_o(l1),
      .deep_sleep_supported_o(l2));
   // Expected register image
   function [31:0] img(input [1:0] p, input e);
      img = {23'h0, e, 4'h0, 2'b10, p};
   endfunction
   task chk(input [31:0] g, input [31:0] e);
      begin
         compares = compares + 1;
         if (g !== e) begin
            bad_count = bad_count + 1;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
         end
      end
   endtask
   task rd(input [31:0] e);
      begin
         HOST.acc(12'h0A4, 1'b0, 4'h0, 32'h0);
         @(posedge clk_i) #1 chk(q, e);
         chk({s, ena, l1, l2}, {st, en, 2'b00});
      end
   endtask
   task end_of_test;
      begin
         if (bad_count == 0 && compares > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   initial begin
      #5000 bad_count = bad_count + 1;
      end_of_test;
   end
   // Reset, random writes with read-back, then both wake kinds
   initial begin
      i = $urandom(32'hB952F933);
      {st, en} = 3'h0;
      repeat (8) @(posedge clk_i);
      #1 rstn_i = 1;
      rd(32'h8);
      // Corner: all ones with a D2 request, state must stay
      HOST.acc(12'h0A4, 1'b1, 4'hF, 32'hFFFFFFFE);
      en = 1'b1;
      rd(img(st, en));
      for (i = 0; i < 40; i = i + 1) begin
         r = $urandom;
         adr = r[31] ? 12'h0A4 : r[11:0];
         HOST.acc(adr, 1'b1, r[27:24], r);
         if (adr == 12'h0A4 && r[25]) en = r[8];
         if (adr == 12'h0A4 && r[24] && r[0] == r[1]) st = r[1:0];
         rd(img(st, en));
      end
      // Wake kind settles two edges before reset starts
      for (i = 0; i < 2; i = i + 1) begin
         HOST.acc(12'h0A4, 1'b1, 4'h3, 32'h103);
         cold_wake_i = !i[0];
         {st, en} = 3'h7;
         rd(img(st, en));
         rstn_i = 0;
         repeat (2) @(posedge clk_i);
         #1 rstn_i = 1;
         {st, en} = {2'b00, !i[0]};
         rd(img(st, en));
      end
      end_of_test;
   end
endmodule
